// ### gis_port.sv
// interrupt status, interrupt clear and alternate-function select of one 8-pin gpio port
// assumes edge/level sense and mask registers live elsewhere in the port; they arrive as
// irq_event pulses and the irq_mask level; lock/commit state arrives as plain levels
//
// Contract
// - a masked status bit reads 1 exactly when raw status and mask are both 1.
// - a masked status bit reads 0 when nothing is pending or it is masked, is read-only, resets to 0.
// - writing 1 to a clear bit clears that pin's raw and masked status, unless its interrupt condition arrives in the same cycle.
// - writing 0 to a clear bit leaves that pin's pending state alone.
// - on port B an unmasked interrupt on pin four also pulses the converter trigger.
// - with alt select 0 the pin is driven and sampled by the gpio logic.
// - with alt select 1 a peripheral chosen by the port-control field owns the pin.
// - reset returns pins to tri-stated gpio with alt, enable, pulls and port-control zero.
// - serial, sync-serial, two-wire and debug pins reset to their listed non-zero values.
// - protected pins take alt, pull and enable writes only when unlocked and committed.
// - bits 31:8 of the status, clear and alt select registers read as zero.
// - a raw status bit is set by its pin's interrupt condition regardless of the mask.
// - a mask bit of 1 passes the pin onto the combined interrupt, 0 blocks it.
`include "gis_map.svh"
module gis_port
  import gis_pkg::*;
#(
  parameter int PORT_ID = `GIS_PORT_A,
  parameter int NFUNC = 16
) (
  input wire logic ref_clk, // 125 MHz clock
  input wire logic rstn, // sync reset, active low
  input wire gis_req_t reg_req, // register access request
  output logic [31:0] reg_rdata, // read data, one cycle after rd
  output logic reg_rvalid, // read data valid pulse
  input wire logic [7:0] irq_event, // interrupt condition pulses from sense logic
  input wire logic [7:0] irq_mask, // interrupt mask levels
  input wire logic cfg_unlocked, // lock register is unlocked
  input wire logic [7:0] commit_bits, // commit enables per pin
  output logic [7:0] raw_status, // raw interrupt status
  output logic [7:0] masked_status, // masked interrupt status
  output logic irq_out, // combined port interrupt, active high
  output logic adc_trigger, // converter trigger pulse
  output logic [7:0] pull_up, // pull-up selects
  output logic [7:0] pull_down, // pull-down selects
  input wire gis_drive_t gpio_drv, // gpio output levels and enables
  output logic [7:0] gpio_in, // pad levels for the gpio logic
  input wire logic [7:0][NFUNC-1:0] periph_out, // peripheral output levels per pin
  input wire logic [7:0][NFUNC-1:0] periph_oe, // peripheral output enables per pin
  output logic [7:0][NFUNC-1:0] periph_in, // pad levels for peripherals per pin
  input wire logic [7:0] pad_in, // pad levels
  output gis_drive_t pad_drv // pad drive levels and enables
);
  localparam logic [7:0] AF_RST = (PORT_ID == `GIS_PORT_C) ? `GIS_RST_C_ALTSEL : `GIS_RST_ZERO8;
  localparam logic [7:0] DEN_RST = (PORT_ID == `GIS_PORT_A) ? `GIS_RST_A_DEN :
                                   (PORT_ID == `GIS_PORT_B) ? `GIS_RST_B_DEN :
                                   (PORT_ID == `GIS_PORT_C) ? `GIS_RST_C_DEN : `GIS_RST_ZERO8;
  localparam logic [7:0] PUR_RST = (PORT_ID == `GIS_PORT_C) ? `GIS_RST_C_PUR : `GIS_RST_ZERO8;
  localparam logic [31:0] PCTL_RST = (PORT_ID == `GIS_PORT_A) ? `GIS_RST_A_PCTL :
                                     (PORT_ID == `GIS_PORT_B) ? `GIS_RST_B_PCTL :
                                     (PORT_ID == `GIS_PORT_C) ? `GIS_RST_C_PCTL : `GIS_RST_ZERO32;
  localparam logic [7:0] PROT = (PORT_ID == `GIS_PORT_B) ? `GIS_PROT_B :
                                (PORT_ID == `GIS_PORT_C) ? `GIS_PROT_C : `GIS_RST_ZERO8;
  localparam logic HAS_ADC = (PORT_ID == `GIS_PORT_B);

  gis_state_t st_r;
  gis_state_t st_nxt;
  logic [7:0] mstat_now;
  logic [7:0] clr_vec;
  logic [7:0] wr_ok;
  logic [7:0] ev_m;
  logic [7:0] prot_altsel;
  logic [7:0] prot_den;

  assign mstat_now = st_r.raw & irq_mask;
  assign ev_m = irq_event & irq_mask;
  assign clr_vec = (reg_req.wr && reg_req.addr == `GIS_OFS_ICR) ? reg_req.wdata[7:0] : 8'h00;
  // protected bits are writable only while unlocked and committed
  assign wr_ok = ~PROT | (commit_bits & {8{cfg_unlocked}});
  assign prot_altsel = st_r.altsel & PROT;
  assign prot_den = st_r.den & PROT;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.trig = 1'b0;
    // a new event in the clear cycle survives: set wins over clear
    st_nxt.raw = (st_r.raw & ~clr_vec) | irq_event;
    st_nxt.mstat4_d = mstat_now[`GIS_ADC_PIN];
    if (HAS_ADC) begin
      st_nxt.trig = mstat_now[`GIS_ADC_PIN] & ~st_r.mstat4_d;
    end
    if (reg_req.wr) begin
      case (reg_req.addr)
        `GIS_OFS_ALTSEL: st_nxt.altsel = (reg_req.wdata[7:0] & wr_ok) | (st_r.altsel & ~wr_ok);
        `GIS_OFS_DEN: st_nxt.den = (reg_req.wdata[7:0] & wr_ok) | (st_r.den & ~wr_ok);
        `GIS_OFS_PUR: st_nxt.pur = (reg_req.wdata[7:0] & wr_ok) | (st_r.pur & ~wr_ok);
        `GIS_OFS_PDR: st_nxt.pdr = (reg_req.wdata[7:0] & wr_ok) | (st_r.pdr & ~wr_ok);
        `GIS_OFS_PCTL: st_nxt.pctl = reg_req.wdata;
        default: st_nxt.pctl = st_r.pctl;
      endcase
    end
    if (reg_req.rd) begin
      st_nxt.rvalid = 1'b1;
      case (reg_req.addr)
        `GIS_OFS_RIS: st_nxt.rdata = {24'h00_0000, st_r.raw};
        `GIS_OFS_MSTAT: st_nxt.rdata = {24'h00_0000, mstat_now};
        `GIS_OFS_ALTSEL: st_nxt.rdata = {24'h00_0000, st_r.altsel};
        `GIS_OFS_DEN: st_nxt.rdata = {24'h00_0000, st_r.den};
        `GIS_OFS_PUR: st_nxt.rdata = {24'h00_0000, st_r.pur};
        `GIS_OFS_PDR: st_nxt.rdata = {24'h00_0000, st_r.pdr};
        `GIS_OFS_PCTL: st_nxt.rdata = st_r.pctl;
        default: st_nxt.rdata = 32'h0000_0000; // clear register and holes read zero
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.altsel <= AF_RST;
      st_r.den <= DEN_RST;
      st_r.pur <= PUR_RST;
      st_r.pctl <= PCTL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign raw_status = st_r.raw;
  assign masked_status = mstat_now;
  assign irq_out = |mstat_now;
  assign adc_trigger = st_r.trig;
  assign pull_up = st_r.pur;
  assign pull_down = st_r.pdr;

  genvar gi;
  generate
    for (gi = 0; gi < `GIS_PINS; gi++) begin : g_pin
      gis_pin_mux #(.NFUNC(NFUNC), .SELW(`GIS_PCTL_W)) u_mux (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .alt_sel(st_r.altsel[gi]),
        .den(st_r.den[gi]),
        .sel(st_r.pctl[gi*`GIS_PCTL_W +: `GIS_PCTL_W]),
        .gpio_out(gpio_drv.out[gi]),
        .gpio_oe(gpio_drv.oe[gi]),
        .periph_out(periph_out[gi]),
        .periph_oe(periph_oe[gi]),
        .pad_in(pad_in[gi]),
        .pad_out(pad_drv.out[gi]),
        .pad_oe(pad_drv.oe[gi]),
        .gpio_in(gpio_in[gi]),
        .periph_in(periph_in[gi])
      );
    end
  endgenerate

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_MSTAT_READ: assert property (
    reg_req.rd && reg_req.addr == `GIS_OFS_MSTAT |=> reg_rvalid
      && reg_rdata == {24'h0, $past(mstat_now)})
    else $error("masked status read is not raw and mask");
  AST_RESET_STATE: assert property (disable iff (1'b0)
    !rstn |=> raw_status == 8'h00 && masked_status == 8'h00 && !irq_out)
    else $error("status not zero after reset");
  AST_ICR_CLEAR: assert property (
    clr_vec != 8'h00 |=> (raw_status & $past(clr_vec) & ~$past(irq_event)) == 8'h00)
    else $error("written one did not clear pending status");
  AST_ICR_KEEP: assert property (
    clr_vec != 8'h00 |=> ($past(raw_status) & ~$past(clr_vec) & ~raw_status) == 8'h00)
    else $error("written zero disturbed pending status");
  AST_ADC_PULSE: assert property (
    HAS_ADC && $rose(mstat_now[`GIS_ADC_PIN]) |=> adc_trigger ##1 !adc_trigger)
    else $error("converter trigger not a single pulse after pin four interrupt");
  AST_RESET_PINS: assert property (disable iff (1'b0)
    !rstn |=> st_r.altsel == AF_RST && st_r.den == DEN_RST && st_r.pur == PUR_RST
      && st_r.pdr == 8'h00 && st_r.pctl == PCTL_RST)
    else $error("pin configuration reset values wrong");
  AST_PROTECT: assert property (
    reg_req.wr && !cfg_unlocked |=> prot_altsel == $past(prot_altsel)
      && prot_den == $past(prot_den))
    else $error("protected pin setting changed while locked");
  AST_HIGH_ZERO: assert property (
    reg_req.rd && reg_req.addr != `GIS_OFS_PCTL |=> reg_rdata[31:8] == 24'h0)
    else $error("reserved bits read non-zero");
  AST_RAW_SET: assert property (
    irq_event != 8'h00 |=> (raw_status & $past(irq_event)) == $past(irq_event))
    else $error("interrupt condition did not set raw status");
  AST_IRQ_OUT: assert property (
    ev_m != 8'h00 ##1 (irq_mask & $past(ev_m)) != 8'h00 |-> irq_out)
    else $error("unmasked pending interrupt not on combined line");
  AST_RAW_READ: assert property (
    reg_req.rd && reg_req.addr == `GIS_OFS_RIS |=> reg_rdata == {24'h0, $past(raw_status)})
    else $error("raw status read differs from raw status");
  AST_CLEAR_READS_ZERO: assert property (
    reg_req.rd && reg_req.addr == `GIS_OFS_ICR |=> reg_rdata == 32'h0000_0000)
    else $error("clear register did not read zero");
  AST_PCTL_WRITE: assert property (
    reg_req.wr && reg_req.addr == `GIS_OFS_PCTL |=> st_r.pctl == $past(reg_req.wdata))
    else $error("port-control write did not land");
  AST_PROTECT_PULL: assert property (
    reg_req.wr && !cfg_unlocked |=> (pull_up & PROT) == ($past(pull_up) & PROT)
      && (pull_down & PROT) == ($past(pull_down) & PROT))
    else $error("protected pull setting changed while locked");
  // the commit path must really open, not only the lock path stay shut
  AST_COMMIT_TAKES: assert property (
    reg_req.wr && reg_req.addr == `GIS_OFS_ALTSEL && cfg_unlocked
      && (commit_bits & PROT) == PROT
      |=> (st_r.altsel & PROT) == ($past(reg_req.wdata[7:0]) & PROT))
    else $error("committed alt select write did not land");
  AST_TRIG_CAUSE: assert property (
    adc_trigger |-> HAS_ADC && $past(masked_status[`GIS_ADC_PIN]))
    else $error("converter trigger without a pin four interrupt");

  COV_CLEAR: cover property (raw_status != 8'h00 ##1 clr_vec != 8'h00 ##1 raw_status == 8'h00);
  COV_ADC: cover property (adc_trigger);
  COV_COMMIT: cover property (reg_req.wr && reg_req.addr == `GIS_OFS_ALTSEL && cfg_unlocked
    && (commit_bits & PROT) != 8'h00);
  COV_IRQ: cover property ($rose(irq_out));
endmodule

// ### gis_map.svh
// register offsets, reset values and field positions of the gpio interrupt/alt-function block
// assumes a 12-bit byte offset inside the port aperture
`ifndef GIS_MAP_SVH
`define GIS_MAP_SVH

`define GIS_OFS_RIS 12'h414
`define GIS_OFS_MSTAT 12'h418
`define GIS_OFS_ICR 12'h41c
`define GIS_OFS_ALTSEL 12'h420
`define GIS_OFS_DEN 12'h424
`define GIS_OFS_PUR 12'h428
`define GIS_OFS_PDR 12'h42c
`define GIS_OFS_PCTL 12'h430

`define GIS_PINS 8
`define GIS_PCTL_W 4
`define GIS_ADC_PIN 4

`define GIS_PORT_A 0
`define GIS_PORT_B 1
`define GIS_PORT_C 2

`define GIS_RST_ZERO8 8'h00
`define GIS_RST_ZERO32 32'h0000_0000
`define GIS_RST_A_DEN 8'h3f
`define GIS_RST_A_PCTL 32'h0011_1111
`define GIS_RST_B_DEN 8'h0c
`define GIS_RST_B_PCTL 32'h0000_3300
`define GIS_RST_C_ALTSEL 8'h0f
`define GIS_RST_C_DEN 8'h0f
`define GIS_RST_C_PUR 8'h0f
`define GIS_RST_C_PCTL 32'h0000_1111

`define GIS_PROT_B 8'h80
`define GIS_PROT_C 8'h0f

`endif

// ### gis_pkg.sv
// types shared by the gpio interrupt/alt-function block
// assumes gis_map.svh is on the include path
package gis_pkg;
  `include "gis_map.svh"

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } gis_req_t;

  typedef struct packed {
    logic [7:0] raw;
    logic [7:0] altsel;
    logic [7:0] den;
    logic [7:0] pur;
    logic [7:0] pdr;
    logic [31:0] pctl;
    logic [31:0] rdata;
    logic rvalid;
    logic mstat4_d;
    logic trig;
  } gis_state_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gis_drive_t;
endpackage

// ### gis_pin_mux.sv
// one pad's owner selection between the gpio logic and up to NFUNC peripherals
// assumes pad_in is already synchronous to ref_clk
module gis_pin_mux
  import gis_pkg::*;
#(
  parameter int NFUNC = 16,
  parameter int SELW = 4
) (
  input wire logic ref_clk, // clock for checks only
  input wire logic rstn, // sync reset, active low
  input wire logic alt_sel, // 1: peripheral owns the pad
  input wire logic den, // digital enable
  input wire logic [SELW-1:0] sel, // peripheral function select
  input wire logic gpio_out, // gpio output level
  input wire logic gpio_oe, // gpio output enable
  input wire logic [NFUNC-1:0] periph_out, // peripheral output levels
  input wire logic [NFUNC-1:0] periph_oe, // peripheral output enables
  input wire logic pad_in, // pad level
  output logic pad_out, // pad drive level
  output logic pad_oe, // pad drive enable, high while driving
  output logic gpio_in, // pad level seen by the gpio logic
  output logic [NFUNC-1:0] periph_in // pad level seen by the chosen peripheral
);
  always_comb begin
    periph_in = '0;
    if (alt_sel) begin
      pad_out = periph_out[sel];
      pad_oe = den & periph_oe[sel];
      gpio_in = 1'b0;
      periph_in[sel] = pad_in & den;
    end else begin
      pad_out = gpio_out;
      pad_oe = den & gpio_oe;
      gpio_in = pad_in & den;
    end
  end

  AST_GPIO_OWNS: assert property (@(posedge ref_clk) disable iff (!rstn)
    !alt_sel && den |-> pad_oe == gpio_oe && gpio_in == pad_in && periph_in == '0)
    else $error("gpio does not own a pad with alt select clear");
  AST_PERIPH_OWNS: assert property (@(posedge ref_clk) disable iff (!rstn)
    alt_sel && den |-> pad_oe == periph_oe[sel] && pad_out == periph_out[sel] && !gpio_in)
    else $error("selected peripheral does not own a pad with alt select set");
endmodule

// ### gis_pad_model.sv
// pad and peripheral model facing one gis_port
// assumes pad levels settle within the cycle; an undriven pad without pulls toggles
module gis_pad_model
  import gis_pkg::*;
#(
  parameter int NFUNC = 16
) (
  input wire logic ref_clk, // clock
  input wire gis_drive_t pad_drv, // pad drive from the port
  input wire logic [7:0] pull_up, // pull-up selects
  input wire logic [7:0] pull_down, // pull-down selects
  output logic [7:0] pad_in, // resolved pad levels
  output logic [7:0][NFUNC-1:0] periph_out, // odd functions drive 1, even 0
  output logic [7:0][NFUNC-1:0] periph_oe // every function drives
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_r = 1'b0;
  always_ff @(posedge ref_clk) begin
    flip_r <= ~flip_r;
  end
  // a floating pad must not settle to a stable level the bench could trust
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_drv.oe[i] ? pad_drv.out[i] : (pull_up[i] | (~pull_down[i] & flip_r));
      for (int f = 0; f < NFUNC; f++) begin
        periph_out[i][f] = f[0];
        periph_oe[i][f] = 1'b1;
      end
    end
  end
endmodule

// ### tb_gis_port.sv
// self-checking bench for gis_port built as port B
// assumes gis_pad_model stands for the pads and peripherals
module tb_gis_port
  import gis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] ev, mask, clr, raw, mstat;} gis_row_t;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  gis_req_t reg_req = '0;
  logic [7:0] irq_event = '0;
  logic [7:0] irq_mask = '0;
  logic [7:0] commit_bits = '0;
  logic cfg_unlocked = 1'b0;
  gis_drive_t gpio_drv = '{out: 8'h55, oe: 8'hff};
  logic [31:0] reg_rdata;
  logic reg_rvalid, irq_out, adc_trigger;
  logic [7:0] raw_status, masked_status, pull_up, pull_down, gpio_in, pad_in;
  logic [7:0][15:0] periph_out, periph_oe, periph_in;
  gis_drive_t pad_drv;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  gis_row_t rows [6] = '{
    '{8'h81, 8'h01, 8'h00, 8'h81, 8'h01}, '{8'h00, 8'h80, 8'h00, 8'h81, 8'h80},
    '{8'h00, 8'hff, 8'h01, 8'h80, 8'h80}, '{8'h00, 8'hff, 8'h80, 8'h00, 8'h00},
    '{8'h3c, 8'h0f, 8'h00, 8'h3c, 8'h0c}, '{8'h02, 8'h0f, 8'h3c, 8'h02, 8'h02}};

  gis_port #(.PORT_ID(1), .NFUNC(16)) i_gis_port (.ref_clk(ref_clk), .rstn(rstn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .irq_event(irq_event), .irq_mask(irq_mask), .cfg_unlocked(cfg_unlocked),
    .commit_bits(commit_bits), .raw_status(raw_status), .masked_status(masked_status),
    .irq_out(irq_out), .adc_trigger(adc_trigger), .pull_up(pull_up), .pull_down(pull_down),
    .gpio_drv(gpio_drv), .gpio_in(gpio_in), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .pad_in(pad_in), .pad_drv(pad_drv));
  gis_pad_model #(.NFUNC(16)) i_gis_pad_model (.ref_clk(ref_clk), .pad_drv(pad_drv),
    .pull_up(pull_up), .pull_down(pull_down), .pad_in(pad_in), .periph_out(periph_out),
    .periph_oe(periph_oe));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask
  task automatic rdchk(string what, logic [11:0] a, logic [31:0] exp);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    chk({what, "_valid"}, 32'h1, {31'h0, reg_rvalid});
    chk(what, exp, reg_rdata);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      $display("BAD run_length expected 2000 seen more");
      tally_and_finish();
    end
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk("pad_oe", 8'h0c, pad_drv.oe);
    chk("pulls", 16'h0, {pull_up, pull_down});
    chk("irq_rst", 0, {irq_out, adc_trigger, raw_status});
    rdchk("altsel_rst", 12'h420, 32'h0);
    rdchk("den_rst", 12'h424, 32'h0c);
    rdchk("pctl_rst", 12'h430, 32'h3300);
    rdchk("mstat_rst", 12'h418, 32'h0);
    $display("done: reset values");
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      irq_mask <= rows[i].mask;
      @(posedge ref_clk);
      irq_event <= rows[i].ev;
      @(posedge ref_clk);
      irq_event <= '0;
      wr(12'h41c, {24'h0, rows[i].clr});
      #1;
      chk("raw", rows[i].raw, raw_status);
      chk("masked", rows[i].mstat, masked_status);
      chk("irq_out", |rows[i].mstat, irq_out);
      rdchk("mstat_reg", 12'h418, rows[i].mstat);
      rdchk("raw_reg", 12'h414, rows[i].raw);
      rdchk("icr_reg", 12'h41c, 32'h0);
      chk("no_trig", 0, adc_trigger);
    end
    // event and clear on the same edge: the new event must survive
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: 12'h41c, wdata: 32'h03};
    irq_event <= 8'h01;
    @(posedge ref_clk);
    reg_req <= '0;
    irq_event <= '0;
    #1;
    chk("set_wins", 8'h01, raw_status);
    $display("done: status rows");
    wr(12'h41c, 32'hff);
    irq_mask <= 8'h10;
    @(posedge ref_clk);
    irq_event <= 8'h10;
    @(posedge ref_clk);
    irq_event <= '0;
    #1;
    chk("irq_b4", 1, irq_out);
    @(posedge ref_clk);
    #1;
    chk("trig_on", 1, adc_trigger);
    @(posedge ref_clk);
    #1;
    chk("trig_off", 0, adc_trigger);
    $display("done: converter trigger");
    wr(12'h420, 32'hffff_ffff); // pins 6:0 take alt select, locked pin 7 keeps it clear
    rdchk("altsel_lock", 12'h420, 32'h7f);
    wr(12'h424, 32'hff);
    rdchk("den_lock", 12'h424, 32'h7f);
    wr(12'h428, 32'hff);
    wr(12'h42c, 32'h81);
    #1;
    chk("pull_lock", 16'h7f01, {pull_up, pull_down});
    @(posedge ref_clk);
    cfg_unlocked <= 1'b1;
    commit_bits <= 8'h80; // only the nmi pin is committed, unprotected pins 6:0 take the write as well
    wr(12'h420, 32'h81);
    rdchk("altsel_commit", 12'h420, 32'h81);
    $display("done: protected pins");
    wr(12'h430, 32'h2);
    #1;
    chk("pad_out_f2", 8'h54, pad_drv.out & pad_drv.oe);
    chk("pad_oe_mux", 8'h7f, pad_drv.oe);
    wr(12'h430, 32'h3);
    #1;
    chk("pad_out_f3", 8'h55, pad_drv.out & pad_drv.oe);
    chk("gpio_in", 8'h54, gpio_in);
    chk("periph_in", 16'h0008, periph_in[0]);
    rdchk("unmapped", 12'h7fc, 32'h0);
    $display("done: pin ownership");
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk("raw_rerst", 0, raw_status);
    rdchk("altsel_rerst", 12'h420, 32'h0);
    chk("pulls_rerst", 16'h0, {pull_up, pull_down});
    $display("done: second reset");
    tally_and_finish();
  end
endmodule
